// file: logic/ecrs_pkg.sv
package ecrs_pkg;

    // Clock rates, in hertz
    localparam int unsigned CLK_SYS_HZ  = 50_000_000;
    localparam int unsigned SCLK_MAX_HZ = 3_600_000;

    // Shortest legal serial clock period in system cycles; a shortest-time figure, and the integer division rounds it down
    localparam int unsigned SCLK_MIN_PERIOD_CYC_I = CLK_SYS_HZ / SCLK_MAX_HZ;

    // Delay counts, in external conversion clock cycles
    localparam int unsigned CNT_W            = 8;
    localparam logic [7:0]  AIN_WAKE_CYC     = 8'hda;   // 218
    localparam logic [7:0]  TEMP_SETTLE_CYC  = 8'hf4;   // 244
    localparam logic [7:0]  TEMP_OUTPUT_CYC  = 8'hbc;   // 188

    // Period measurement of the serial clock
    localparam int unsigned PER_W            = 5;
    localparam logic [4:0]  PER_MAX          = 5'h1f;
    localparam logic [4:0]  PER_ONE          = 5'h01;
    localparam logic [4:0]  SCLK_MIN_PERIOD_CYC = SCLK_MIN_PERIOD_CYC_I[4:0];

    // Reference select codes {ref_select_hi, ref_select_lo}
    typedef enum logic [1:0] {
        ECRS_REF_INT_BOTH  = 2'h0,
        ECRS_REF_EXT_SE    = 2'h1,
        ECRS_REF_INT_ADC   = 2'h2,
        ECRS_REF_EXT_DIFF  = 2'h3
    } ecrs_ref_t;

    // Clock select codes {clock_select_hi, clock_select_lo}
    localparam logic [1:0] CLK_MODE_EXTERNAL = 2'h3;

    // Reset values of the held settings
    localparam ecrs_ref_t  REF_RESET       = ECRS_REF_INT_ADC;
    localparam logic [1:0] CLK_MODE_RESET  = 2'h2;

endpackage

// file: logic/ecrs_cnt_if.sv
`timescale 1ns/1ps
// Carries a delay request from the system domain to the serial clock counter and its completion back
interface ecrs_cnt_if;
    logic             req_tgl;   // Toggles once per delay request
    logic [7:0]       target;    // Cycle count, stable while a request is open
    logic             done_tgl;  // Toggles once per finished delay

    modport seq  (output req_tgl, output target, input  done_tgl);
    modport link (input  req_tgl, input  target, output done_tgl);
endinterface

// file: logic/ecrs_link_counter.sv
`timescale 1ns/1ps
module ecrs_link_counter
    import ecrs_pkg::*;
(
    input  wire logic  sclk,        // Serial clock from the host
    input  wire logic  rst_b,       // Asynchronous reset, active low
    ecrs_cnt_if.link   cnt          // Request and completion toggles
);

    logic             rst_s1;
    logic             rst_s2;
    logic             req_s1;
    logic             req_s2;
    logic             req_s3;
    logic             run;
    logic [CNT_W-1:0] remain;
    logic             done_tgl;

    ////////////////////////////////////////////////////////////////////////////
    // Release of reset is retimed to the serial clock
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sclk or negedge rst_s2) begin
        if (!rst_s2) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= cnt.req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // Delays advance only on host clock edges, so a stopped clock stalls them
    always_ff @(posedge sclk or negedge rst_s2) begin
        if (!rst_s2) begin
            run      <= 1'b0;
            remain   <= '0;
            done_tgl <= 1'b0;
        end else if (req_s2 != req_s3) begin
            run    <= 1'b1;
            remain <= cnt.target;
        end else if (run) begin
            if (remain == CNT_W'(1)) begin
                run      <= 1'b0;
                done_tgl <= ~done_tgl;
            end
            remain <= remain - CNT_W'(1);
        end
    end

    assign cnt.done_tgl = done_tgl;

endmodule // ecrs_link_counter

// file: logic/ecrs_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - External mode times delays from host clock
// - Internal reference off after scan completes
// - Reference off: wait 218 clocks before conversion
// - Temperature forces reference on, waits 244 if it was off
// - Temperature result after 188 further clocks
// - External reference: reference off, no delay
// - Reset reference mode is internal ADC
// - Default mode: ADC internal, DAC pin
module ecrs_sequencer
    import ecrs_pkg::*;
(
    input  wire logic  clk_sys,                 // System clock, 50 MHz
    input  wire logic  rst_b,                   // Asynchronous reset, active low
    input  wire logic  sclk,                    // Serial clock driven by the host
    input  wire logic  cfg_write,               // Pulse: load the select inputs
    input  wire logic  ref_select_hi,           // Reference select, high bit
    input  wire logic  ref_select_lo,           // Reference select, low bit
    input  wire logic  clock_select_hi,         // Clock mode select, high bit
    input  wire logic  clock_select_lo,         // Clock mode select, low bit
    input  wire logic  ain_req,                 // Pulse: analog input conversion wanted
    input  wire logic  temp_req,                // Pulse: temperature measurement wanted
    input  wire logic  scan_done,               // Pulse: current scan finished
    output logic       int_ref_power,           // Internal reference powered
    output logic       adc_ref_internal,        // ADC runs from internal reference
    output logic       dac_ref_internal,        // DAC runs from internal reference
    output logic       dac_reference_pin_en,    // DAC runs from its reference pin
    output logic       adc_reference_pin_en,    // ADC reference pin used as reference
    output logic       shared_analog_input_en,  // ADC reference pin used as analog input
    output logic       adc_ref_differential,    // ADC reference taken differentially
    output logic       conv_start,              // Pulse: start an analog conversion
    output logic       temp_result_ready,       // Pulse: temperature result on data out
    output logic       busy,                    // A delay is running
    output logic       ext_clock_mode,          // External clock mode selected
    output logic       sclk_overspeed           // Sticky: host clock above its limit
);

    typedef enum logic [1:0] {
        ECRS_IDLE,
        ECRS_AIN_WAKE,
        ECRS_TEMP_SETTLE,
        ECRS_TEMP_OUTPUT
    } ecrs_state_t;

    ecrs_cnt_if cnt ();

    // Sequence state and held settings
    ecrs_state_t      state;
    ecrs_ref_t        ref_mode;
    logic [1:0]       clk_mode;

    // Handshake with the host-clock counter
    logic             req_tgl;
    logic [CNT_W-1:0] target;
    logic             done_s1;
    logic             done_s2;
    logic             done_s3;
    logic             done_evt;

    // Decoded settings
    logic             ext_mode;
    logic             adc_int_sel;
    logic             ref_off_after_temp;

    // Host clock speed watch
    logic             sck_s1;
    logic             sck_s2;
    logic             sck_s3;
    logic             sck_rise;
    logic [PER_W-1:0] period;
    logic             period_valid;

    // Requests taken this cycle
    logic             start_ain;
    logic             start_temp;

    ////////////////////////////////////////////////////////////////////////////
    // Delay counter on the host clock
    ecrs_link_counter u_link (
        .sclk  (sclk),
        .rst_b (rst_b),
        .cnt   (cnt.link)
    );

    // Target settles two host clocks before the counter reads it
    assign cnt.req_tgl = req_tgl;
    assign cnt.target  = target;

    ////////////////////////////////////////////////////////////////////////////
    // Held settings; reset lands in the internal-ADC, external-DAC mode
    // A load is taken mid-sequence too; the running delay keeps its length
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ref_mode <= REF_RESET;
            clk_mode <= CLK_MODE_RESET;
        end else if (cfg_write) begin
            ref_mode <= ecrs_ref_t'({ref_select_hi, ref_select_lo});
            clk_mode <= {clock_select_hi, clock_select_lo};
        end
    end

    assign ext_mode    = (clk_mode == CLK_MODE_EXTERNAL);
    assign adc_int_sel = (ref_mode == ECRS_REF_INT_BOTH)
                         || (ref_mode == ECRS_REF_INT_ADC);

    // New requests are refused while a delay runs; only the idle state takes them
    assign start_ain  = ain_req && ext_mode && (state == ECRS_IDLE);
    assign start_temp = temp_req && ext_mode && (state == ECRS_IDLE) && !ain_req;

    ////////////////////////////////////////////////////////////////////////////
    // Reference routing
    // Outputs follow the held mode one cycle late, straight from flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adc_ref_internal       <= 1'b1;
            dac_ref_internal       <= 1'b0;
            dac_reference_pin_en   <= 1'b1;
            adc_reference_pin_en   <= 1'b0;
            shared_analog_input_en <= 1'b1;
            adc_ref_differential   <= 1'b0;
            ext_clock_mode         <= 1'b0;
        end else begin
            adc_ref_internal       <= adc_int_sel;
            dac_ref_internal       <= (ref_mode == ECRS_REF_INT_BOTH);
            dac_reference_pin_en   <= (ref_mode != ECRS_REF_INT_BOTH);
            adc_reference_pin_en   <= !adc_int_sel;
            shared_analog_input_en <= adc_int_sel;
            adc_ref_differential   <= (ref_mode == ECRS_REF_EXT_DIFF);
            ext_clock_mode         <= ext_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion of a delay crosses back from the host clock
    // The third flop only marks the toggle; the first only feeds the second
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            done_s1 <= cnt.done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    assign done_evt = done_s2 ^ done_s3;

    ////////////////////////////////////////////////////////////////////////////
    // Sequence of wake-up and settling delays
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state   <= ECRS_IDLE;
            req_tgl <= 1'b0;
            target  <= '0;
        end else begin
            unique case (state)
                ECRS_IDLE: begin
                    if (start_ain && adc_int_sel && !int_ref_power) begin
                        target  <= AIN_WAKE_CYC;
                        req_tgl <= ~req_tgl;
                        state   <= ECRS_AIN_WAKE;
                    end else if (start_temp && !int_ref_power) begin
                        target  <= TEMP_SETTLE_CYC;
                        req_tgl <= ~req_tgl;
                        state   <= ECRS_TEMP_SETTLE;
                    end else if (start_temp) begin
                        // A live reference goes straight to the result delay
                        target  <= TEMP_OUTPUT_CYC;
                        req_tgl <= ~req_tgl;
                        state   <= ECRS_TEMP_OUTPUT;
                    end
                end

                ECRS_AIN_WAKE: begin
                    // The strobe process raises conv_start on this same edge
                    if (done_evt) begin
                        state <= ECRS_IDLE;
                    end
                end

                ECRS_TEMP_SETTLE: begin
                    // Second leg of a cold temperature run
                    if (done_evt) begin
                        target  <= TEMP_OUTPUT_CYC;
                        req_tgl <= ~req_tgl;
                        state   <= ECRS_TEMP_OUTPUT;
                    end
                end

                ECRS_TEMP_OUTPUT: begin
                    if (done_evt) begin
                        state <= ECRS_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power of the internal reference
    // An external-reference mode only wakes it for temperature and drops it afterwards
    // Requests outrank power-down, so no sequence starts on a cold reference
    // Scan end counts only when idle; a running delay keeps the reference
    assign ref_off_after_temp = (state == ECRS_TEMP_OUTPUT) && done_evt && !adc_int_sel;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            int_ref_power <= 1'b0;
        end else if (start_temp) begin
            int_ref_power <= 1'b1;
        end else if (start_ain && adc_int_sel) begin
            int_ref_power <= 1'b1;
        end else if (ref_off_after_temp) begin
            int_ref_power <= 1'b0;
        end else if (scan_done && state == ECRS_IDLE && adc_int_sel) begin
            int_ref_power <= 1'b0;
        end else if (state == ECRS_IDLE && !adc_int_sel && !start_temp) begin
            int_ref_power <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start and result strobes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            conv_start <= 1'b0;
        end else begin
            // External reference or a live reference converts at once
            conv_start <= (start_ain && !(adc_int_sel && !int_ref_power))
                          || (state == ECRS_AIN_WAKE && done_evt);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            temp_result_ready <= 1'b0;
        end else begin
            // One-cycle result strobe on the closing edge
            temp_result_ready <= (state == ECRS_TEMP_OUTPUT) && done_evt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != ECRS_IDLE)
                    || (start_ain && adc_int_sel && !int_ref_power)
                    || start_temp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host clock speed watch: the host clock is sampled as data here, never used as a clock
    // Two flops settle the sampled clock; the third marks its rise
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
        end else begin
            sck_s1 <= sclk;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    assign sck_rise = sck_s2 && !sck_s3;

    // Saturating count; a stopped clock between frames only lengthens the period
    // Count restarts at one so it equals the rise-to-rise distance
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            period       <= '0;
            period_valid <= 1'b0;
        end else if (!ext_mode) begin
            period       <= '0;
            period_valid <= 1'b0;
        end else if (sck_rise) begin
            period       <= PER_ONE;
            period_valid <= 1'b1;
        end else if (period != PER_MAX) begin
            period <= period + PER_ONE;
        end
    end

    // Sampling cannot see clocks above half the system rate; those alias and may pass unseen
    // A rise beats a clear when both land in one cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclk_overspeed <= 1'b0;
        end else if (sck_rise && period_valid && period < SCLK_MIN_PERIOD_CYC) begin
            sclk_overspeed <= 1'b1;
        end else if (cfg_write) begin
            sclk_overspeed <= 1'b0;
        end
    end

endmodule // ecrs_sequencer

// file: tb/ecrs_host_clock_model.sv
`timescale 1ns/1ps
// Host side: drives the serial clock only while a frame is open, parked low otherwise
module ecrs_host_clock_model (
    input  wire logic run,   // Frame open, clock runs
    input  wire logic slow,  // Slow host: doubles the period
    output logic      sclk   // Serial clock to the device
);
    // Odd start offset keeps the phase unrelated to the system clock
    initial begin
        sclk = 1'b0;
        #1.3;
        forever begin
            // A closing frame finishes its high phase, so no runt pulse reaches the device
            if (run || sclk) begin
                #(slow ? 12.0 : 6.0);
                sclk = ~sclk;
            end else begin
                #1.0;
            end
        end
    end
endmodule // ecrs_host_clock_model

// file: tb/ecrs_sequencer_properties.sv
`timescale 1ns/1ps
module ecrs_sequencer_properties
    import ecrs_pkg::*;
(
    input wire logic clk_sys,                // System clock
    input wire logic rst_b,                  // Reset, active low
    input wire logic sclk,                   // Host clock
    input wire logic cfg_write,              // Config load
    input wire logic ref_select_hi,          // Ref select hi
    input wire logic ref_select_lo,          // Ref select lo
    input wire logic clock_select_hi,        // Clock select hi
    input wire logic clock_select_lo,        // Clock select lo
    input wire logic ain_req,                // Analog request
    input wire logic temp_req,               // Temperature request
    input wire logic scan_done,              // Scan finished
    input wire logic int_ref_power,          // Internal ref on
    input wire logic adc_ref_internal,       // ADC internal ref
    input wire logic dac_ref_internal,       // DAC internal ref
    input wire logic dac_reference_pin_en,   // DAC ref pin
    input wire logic adc_reference_pin_en,   // ADC ref pin
    input wire logic shared_analog_input_en, // Pin as input
    input wire logic adc_ref_differential,   // Differential ref
    input wire logic conv_start,             // Conversion start
    input wire logic temp_result_ready,      // Temperature result
    input wire logic busy,                   // Delay running
    input wire logic ext_clock_mode,         // External clock mode
    input wire logic sclk_overspeed          // Host clock too fast
);
    logic [9:0] sclk_busy_cnt;
    logic [9:0] delay_len;
    ////////////////////////////////////////////////////////////////////////////////
    // Host clock edges seen while busy; snapshot kept in the system domain
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b)
            sclk_busy_cnt <= 10'h000;
        else if (!busy)
            sclk_busy_cnt <= 10'h000;
        else if (sclk_busy_cnt != 10'h3ff)
            sclk_busy_cnt <= sclk_busy_cnt + 10'h001;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            delay_len <= 10'h000;
        else if (busy)
            delay_len <= sclk_busy_cnt;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_ext_idle;
        ext_clock_mode && adc_reference_pin_en && !busy && !conv_start && !temp_result_ready && !cfg_write;
    endsequence
    sequence s_ext_ain;
        s_ext_idle ##0 ain_req;
    endsequence
    a_adc_pin_split: assert property (adc_ref_internal != adc_reference_pin_en)
        else $error("ADC reference source and pin use disagree");
    a_shared_input_use: assert property (shared_analog_input_en == adc_ref_internal)
        else $error("Shared input use does not follow ADC reference");
    a_dac_source_split: assert property (dac_ref_internal != dac_reference_pin_en)
        else $error("DAC reference source and pin disagree");
    a_diff_uses_pin: assert property (adc_ref_differential |-> adc_reference_pin_en && !dac_ref_internal)
        else $error("Differential reference without reference pin");
    a_start_ext_mode: assert property ((conv_start || temp_result_ready) |-> ext_clock_mode)
        else $error("Sequence finished outside external clock mode");
    a_busy_ref_on: assert property (busy && !temp_result_ready |-> int_ref_power)
        else $error("Delay running with internal reference off");
    a_ext_ref_start: assert property (s_ext_ain |=> conv_start && !busy)
        else $error("External reference conversion was delayed");
    a_ext_ref_off: assert property (s_ext_idle [*3] |-> !int_ref_power)
        else $error("Internal reference powered with external reference");
    a_scan_ref_off: assert property (scan_done && !busy && adc_ref_internal && !ain_req && !temp_req
        |-> ##[1:2] !int_ref_power)
        else $error("Internal reference left on after scan");
    a_wake_length: assert property (conv_start && $past(busy) |-> delay_len >= 10'd218 && delay_len <= 10'd236)
        else $error("Wake delay length wrong");
    a_temp_length: assert property (temp_result_ready |-> delay_len >= 10'd188 && delay_len <= 10'd470)
        else $error("Temperature delay length wrong");
endmodule // ecrs_sequencer_properties

bind ecrs_sequencer ecrs_sequencer_properties ecrs_sequencer_properties_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cfg_write(cfg_write), .ref_select_hi(ref_select_hi),
    .ref_select_lo(ref_select_lo), .clock_select_hi(clock_select_hi), .clock_select_lo(clock_select_lo),
    .ain_req(ain_req), .temp_req(temp_req), .scan_done(scan_done), .int_ref_power(int_ref_power),
    .adc_ref_internal(adc_ref_internal), .dac_ref_internal(dac_ref_internal),
    .dac_reference_pin_en(dac_reference_pin_en), .adc_reference_pin_en(adc_reference_pin_en),
    .shared_analog_input_en(shared_analog_input_en), .adc_ref_differential(adc_ref_differential),
    .conv_start(conv_start), .temp_result_ready(temp_result_ready), .busy(busy),
    .ext_clock_mode(ext_clock_mode), .sclk_overspeed(sclk_overspeed));

// file: tb/ecrs_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module ecrs_sequencer_tb_top;
    import ecrs_pkg::*;
    logic       clk_sys   = 1'b0;
    logic       rst_b     = 1'b0;
    logic       sclk_run  = 1'b1;
    logic       sclk_slow = 1'b0;
    logic       cfg_write = 1'b0;
    logic [1:0] ref_sel   = 2'h2;
    logic [1:0] clk_sel   = 2'h2;
    logic       ain_req   = 1'b0;
    logic       temp_req  = 1'b0;
    logic       scan_done = 1'b0;
    logic       sclk, int_ref_power, adc_ref_internal, dac_ref_internal, dac_reference_pin_en;
    logic       adc_reference_pin_en, shared_analog_input_en, adc_ref_differential;
    logic       conv_start, temp_result_ready, busy, ext_clock_mode, sclk_overspeed, seen;
    int         miscompares = 0;
    int         check_count = 0;
    int         edges = 0;

    always #10 clk_sys = ~clk_sys;
    always @(posedge sclk) edges++;

    ecrs_host_clock_model ecrs_host_clock_model_inst (.run(sclk_run), .slow(sclk_slow), .sclk(sclk));
    ecrs_sequencer ecrs_sequencer_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cfg_write(cfg_write), .ref_select_hi(ref_sel[1]),
        .ref_select_lo(ref_sel[0]), .clock_select_hi(clk_sel[1]), .clock_select_lo(clk_sel[0]),
        .ain_req(ain_req), .temp_req(temp_req), .scan_done(scan_done), .int_ref_power(int_ref_power),
        .adc_ref_internal(adc_ref_internal), .dac_ref_internal(dac_ref_internal),
        .dac_reference_pin_en(dac_reference_pin_en), .adc_reference_pin_en(adc_reference_pin_en),
        .shared_analog_input_en(shared_analog_input_en), .adc_ref_differential(adc_ref_differential),
        .conv_start(conv_start), .temp_result_ready(temp_result_ready), .busy(busy),
        .ext_clock_mode(ext_clock_mode), .sclk_overspeed(sclk_overspeed));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cfg(input logic [1:0] r, input logic [1:0] c);
        @(negedge clk_sys);
        ref_sel = r;
        clk_sel = c;
        cfg_write = 1'b1;
        @(negedge clk_sys);
        cfg_write = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Kind 0 analog, 1 temperature, 2 end of scan; returns on the falling edge after the taking edge
    task automatic pulse(input int kind);
        @(negedge clk_sys);
        edges = 0;
        ain_req = (kind == 0);
        temp_req = (kind == 1);
        scan_done = (kind == 2);
        @(negedge clk_sys);
        ain_req = 1'b0;
        temp_req = 1'b0;
        scan_done = 1'b0;
    endtask

    // Bounded wait; a host that stops its clock would otherwise hang here
    task automatic wait_done();
        seen = 1'b0;
        for (int i = 0; i < 2000 && !seen; i++) begin
            @(negedge clk_sys);
            seen = conv_start | temp_result_ready;
        end
        `CHK(seen, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_defaults();
        `CHK({adc_ref_internal, shared_analog_input_en, dac_reference_pin_en}, 3'h7)
        `CHK({dac_ref_internal, int_ref_power, ext_clock_mode, busy, sclk_overspeed}, 5'h00)
    endtask

    task automatic t_ignored_outside_ext();
        sclk_run = 1'b0;
        pulse(0);
        repeat (3) @(negedge clk_sys);
        `CHK({conv_start, busy, int_ref_power}, 3'h0)
    endtask

    task automatic t_wake_then_scan();
        sclk_run = 1'b1;
        cfg(ECRS_REF_INT_ADC, CLK_MODE_EXTERNAL);
        `CHK(ext_clock_mode, 1'b1)
        pulse(0);
        `CHK({busy, int_ref_power}, 2'h3)
        wait_done();
        `CHK(conv_start, 1'b1)
        `CHK(edges >= 218 && edges <= 240, 1'b1)
        pulse(0);
        `CHK({conv_start, busy}, 2'h2)
        pulse(2);
        repeat (2) @(negedge clk_sys);
        `CHK(int_ref_power, 1'b0)
    endtask

    task automatic t_ext_refs();
        sclk_run = 1'b0;
        for (int code = 1; code <= 3; code += 2) begin
            cfg(code[1:0], CLK_MODE_EXTERNAL);
            `CHK({adc_reference_pin_en, shared_analog_input_en, dac_reference_pin_en}, 3'h5)
            `CHK(adc_ref_differential, (code == 3))
            pulse(0);
            `CHK({conv_start, busy, int_ref_power}, 3'h4)
        end
    endtask

    task automatic t_temp_ref_off_slow();
        sclk_run = 1'b1;
        sclk_slow = 1'b1;
        cfg(ECRS_REF_EXT_SE, CLK_MODE_EXTERNAL);
        pulse(1);
        `CHK(int_ref_power, 1'b1)
        wait_done();
        `CHK(temp_result_ready, 1'b1)
        `CHK(edges >= 432 && edges <= 452, 1'b1)
        sclk_slow = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK(int_ref_power, 1'b0)
    endtask

    task automatic t_temp_ref_on();
        cfg(ECRS_REF_INT_BOTH, CLK_MODE_EXTERNAL);
        `CHK({dac_ref_internal, dac_reference_pin_en, adc_ref_internal}, 3'h5)
        pulse(0);
        wait_done();
        pulse(1);
        wait_done();
        `CHK(temp_result_ready, 1'b1)
        `CHK(edges >= 188 && edges <= 208, 1'b1)
        `CHK(sclk_overspeed, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100us;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset_defaults();
        t_ignored_outside_ext();
        t_wake_then_scan();
        t_ext_refs();
        t_temp_ref_off_slow();
        t_temp_ref_on();
        print_verdict();
    end
endmodule // ecrs_sequencer_tb_top
